// ===== csp_consts.svh
// timing and framing constants for the codec serial port
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH

// system clock period in ns (40 MHz)
`define CSP_CLK_NS        25
// system clocks per sample period
`define CSP_SYS_PER_FS    512
// bit clocks per frame and word width
`define CSP_BITS          16
// system clocks per half bit clock
`define CSP_BCK_HALF      (`CSP_SYS_PER_FS / `CSP_BITS / 2)
// initialization sequence length in system clock periods
`define CSP_INIT_CYC      1024
// settling delay after initialization in ns
`define CSP_POST_NS       12800
// settling delay in clock cycles (least time, rounded up)
`define CSP_POST_CYC      ((`CSP_POST_NS + `CSP_CLK_NS - 1) / `CSP_CLK_NS)
// bit index of the frame sync slot and of the msb slot
`define CSP_FS_SLOT       4'hF
`define CSP_MSB_SLOT      4'h0

`endif

// ===== csp_pkg.sv
// types shared by both ends of the codec serial port
package csp_pkg;
	typedef logic [15:0] csp_word_t;
	typedef logic [3:0]  csp_bidx_t;
	typedef enum {
		CSP_ST_PDOWN,
		CSP_ST_INIT,
		CSP_ST_WAIT,
		CSP_ST_RUN
	} csp_state_e;
endpackage

// ===== csp_if.sv
// four wire serial link, power down and master select between the ends
`timescale 1ns/1ps
interface csp_if;
	logic master_sel;
	logic pd_n_o;
	logic pd_n_oe;
	logic h_bck_o;
	logic h_bck_oe;
	logic h_fs_o;
	logic h_fs_oe;
	logic serial_in;
	logic d_bck_o;
	logic d_bck_oe;
	logic d_fs_o;
	logic d_fs_oe;
	logic d_sdout_o;
	logic d_sdout_oe;
	logic bit_clock;
	logic frame_sync;
	logic serial_out;
	logic power_down_n;

	// undriven lines settle low; power down is pulled low
	assign bit_clock    = d_bck_oe ? d_bck_o : (h_bck_oe & h_bck_o);
	assign frame_sync   = d_fs_oe ? d_fs_o : (h_fs_oe & h_fs_o);
	assign serial_out   = d_sdout_oe & d_sdout_o;
	assign power_down_n = pd_n_oe & pd_n_o;

	modport dev (
		input  master_sel,
		input  bit_clock,
		input  frame_sync,
		input  serial_in,
		input  power_down_n,
		output d_bck_o,
		output d_bck_oe,
		output d_fs_o,
		output d_fs_oe,
		output d_sdout_o,
		output d_sdout_oe
	);

	modport host (
		input  bit_clock,
		input  frame_sync,
		input  serial_out,
		output master_sel,
		output pd_n_o,
		output pd_n_oe,
		output h_bck_o,
		output h_bck_oe,
		output h_fs_o,
		output h_fs_oe,
		output serial_in
	);
endinterface

// ===== csp_codec.sv
// codec end: reset and power down sequencing plus serial port
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_codec #(
	parameter int INIT_CYC = `CSP_INIT_CYC,
	parameter int POST_CYC = `CSP_POST_CYC,
	parameter int HALF     = `CSP_BCK_HALF
) (
	input  wire logic          clock,
	input  wire logic          rstn,
	csp_if.dev                 link,
	input  wire csp_pkg::csp_word_t adc_data,
	output logic               adc_take,
	output csp_pkg::csp_word_t dac_data,
	output logic               dac_strobe,
	output logic               data_valid,
	output logic               master
);
	import csp_pkg::*;

	// ==========================================================
	// pin synchronisers
	logic [1:0]  pdn_q;
	logic [2:0]  bck_q;
	logic [1:0]  fs_q;
	logic [1:0]  din_q;
	logic [1:0]  ms_q;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			// power down reads low in reset
			pdn_q <= 2'h0;
			bck_q <= 3'h0;
			fs_q  <= 2'h0;
			din_q <= 2'h0;
			ms_q  <= 2'h0;
		end else begin
			pdn_q <= {pdn_q[0], link.power_down_n};
			bck_q <= {bck_q[1:0], link.bit_clock};
			fs_q  <= {fs_q[0], link.frame_sync};
			din_q <= {din_q[0], link.serial_in};
			ms_q  <= {ms_q[0], link.master_sel};
		end
	end

	// ==========================================================
	// reset and power down sequencer
	csp_state_e  st;
	logic [15:0] cnt;
	logic        run;

	assign run = (st == CSP_ST_RUN);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st  <= CSP_ST_INIT;
			cnt <= 16'h0000;
		end else if (!pdn_q[1]) begin
			st  <= CSP_ST_PDOWN;
			cnt <= 16'h0000;
		end else begin
			unique case (st)
				CSP_ST_PDOWN: begin
					st  <= CSP_ST_INIT;
					cnt <= 16'h0000;
				end
				CSP_ST_INIT: begin
					if (cnt == 16'(INIT_CYC - 1)) begin
						st  <= CSP_ST_WAIT;
						cnt <= 16'h0000;
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
				CSP_ST_WAIT: begin
					if (cnt == 16'(POST_CYC - 1)) begin
						st  <= CSP_ST_RUN;
						cnt <= 16'h0000;
					end else begin
						cnt <= cnt + 16'h0001;
					end
				end
				CSP_ST_RUN: begin
					st <= CSP_ST_RUN;
				end
			endcase
		end
	end

	// mode caught while held or as init starts
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			master <= 1'b0;
		end else if (st == CSP_ST_PDOWN || (st == CSP_ST_INIT && cnt == 16'h0000)) begin
			master <= ms_q[1];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			data_valid <= 1'b0;
		end else begin
			data_valid <= run;
		end
	end

	// ==========================================================
	// bit clock generation and edge events
	logic [7:0]  div;
	logic        bck_o;
	logic        rise;
	logic        fall;

	// master derives bit clock, slave detects edges
	assign rise = master ? (div == 8'(HALF - 1)) : (bck_q[1] & ~bck_q[2]);
	assign fall = master ? (div == 8'(2 * HALF - 1)) : (~bck_q[1] & bck_q[2]);

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			div   <= 8'h00;
			bck_o <= 1'b0;
		end else if (st == CSP_ST_PDOWN || !master) begin
			div   <= 8'h00;
			bck_o <= 1'b0;
		end else begin
			div   <= fall ? 8'h00 : div + 8'h01;
			bck_o <= rise ? 1'b1 : (fall ? 1'b0 : bck_o);
		end
	end

	// ==========================================================
	// frame position
	csp_bidx_t   bidx;
	logic        fs_seen;
	logic        fs_o;
	csp_bidx_t   next_bidx;

	assign next_bidx = fs_seen ? `CSP_MSB_SLOT : bidx + 4'h1;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fs_seen <= 1'b0;
		end else if (rise) begin
			// frame sync taken at rising edge
			fs_seen <= master ? fs_o : fs_q[1];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bidx <= `CSP_MSB_SLOT;
			fs_o <= 1'b0;
		end else if (fall) begin
			// msb slot follows the sync period
			bidx <= next_bidx;
			// frame sync moves on falling edge
			fs_o <= master & (next_bidx == `CSP_FS_SLOT);
		end
	end

	// ==========================================================
	// transmit of adc words
	csp_word_t   tx;
	logic        sdout;
	logic        sdout_oe;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx       <= 16'h0000;
			sdout    <= 1'b0;
			adc_take <= 1'b0;
		end else begin
			adc_take <= 1'b0;
			if (fall) begin
				if (next_bidx == `CSP_MSB_SLOT) begin
					tx       <= run ? {adc_data[14:0], 1'b0} : 16'h0000;
					sdout    <= run & adc_data[15];
					adc_take <= run;
				end else begin
					tx    <= {tx[14:0], 1'b0};
					sdout <= tx[15];
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sdout_oe <= 1'b0;
		end else if (!run) begin
			sdout_oe <= 1'b0;
		end else if (fall && next_bidx == `CSP_MSB_SLOT) begin
			sdout_oe <= 1'b1;
		end
	end

	// ==========================================================
	// receive of dac words
	csp_word_t   rx;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rx         <= 16'h0000;
			dac_data   <= 16'h0000;
			dac_strobe <= 1'b0;
		end else begin
			dac_strobe <= 1'b0;
			if (!run) begin
				dac_data <= 16'h0000;
			end
			if (rise) begin
				rx <= {rx[14:0], din_q[1]};
				if (run && bidx == `CSP_FS_SLOT) begin
					dac_data   <= {rx[14:0], din_q[1]};
					dac_strobe <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// pin drive
	// four wire serial link
	assign link.d_bck_o    = bck_o;
	assign link.d_bck_oe   = master;
	assign link.d_fs_o     = fs_o;
	assign link.d_fs_oe    = master;
	assign link.d_sdout_o  = sdout;
	assign link.d_sdout_oe = sdout_oe;
endmodule

// ===== csp_host.sv
// controller end: clocks in slave mode, words both ways, power down
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_host #(
	parameter int HALF = `CSP_BCK_HALF
) (
	input  wire logic          clock,
	input  wire logic          rstn,
	csp_if.host                link,
	input  wire logic          master_mode,
	input  wire logic          pd_req,
	input  wire csp_pkg::csp_word_t tx_data,
	output logic               tx_take,
	output csp_pkg::csp_word_t rx_data,
	output logic               rx_strobe
);
	import csp_pkg::*;

	// ==========================================================
	// mode, power down and synchronisers
	logic        dev_master;
	logic        pd_n;
	logic [2:0]  bck_q;
	logic [1:0]  fs_q;
	logic [1:0]  dout_q;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dev_master <= 1'b0;
			pd_n       <= 1'b0;
			bck_q      <= 3'h0;
			fs_q       <= 2'h0;
			dout_q     <= 2'h0;
		end else begin
			dev_master <= master_mode;
			pd_n       <= ~pd_req;
			bck_q      <= {bck_q[1:0], link.bit_clock};
			fs_q       <= {fs_q[0], link.frame_sync};
			dout_q     <= {dout_q[0], link.serial_out};
		end
	end

	// ==========================================================
	// bit clock when the codec is slave
	logic [7:0]  div;
	logic        bck_o;
	logic        rise;
	logic        fall;

	assign rise = dev_master ? (bck_q[1] & ~bck_q[2]) : (div == 8'(HALF - 1));
	assign fall = dev_master ? (~bck_q[1] & bck_q[2]) : (div == 8'(2 * HALF - 1));

	// clocks derived from the shared system clock
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			div   <= 8'h00;
			bck_o <= 1'b0;
		end else if (dev_master) begin
			div   <= 8'h00;
			bck_o <= 1'b0;
		end else begin
			div   <= fall ? 8'h00 : div + 8'h01;
			bck_o <= rise ? 1'b1 : (fall ? 1'b0 : bck_o);
		end
	end

	// ==========================================================
	// frame position
	csp_bidx_t   bidx;
	logic        fs_seen;
	logic        fs_o;
	csp_bidx_t   next_bidx;

	assign next_bidx = fs_seen ? `CSP_MSB_SLOT : bidx + 4'h1;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fs_seen <= 1'b0;
		end else if (rise) begin
			fs_seen <= dev_master ? fs_q[1] : fs_o;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bidx <= `CSP_MSB_SLOT;
			fs_o <= 1'b0;
		end else if (fall) begin
			bidx <= next_bidx;
			// one bit period high, set on falling edge
			fs_o <= ~dev_master & (next_bidx == `CSP_FS_SLOT);
		end
	end

	// ==========================================================
	// words to the dac, launched on falling edge
	csp_word_t   tx;
	logic        sdin;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx      <= 16'h0000;
			sdin    <= 1'b0;
			tx_take <= 1'b0;
		end else begin
			tx_take <= 1'b0;
			if (fall) begin
				if (next_bidx == `CSP_MSB_SLOT) begin
					tx      <= {tx_data[14:0], 1'b0};
					sdin    <= tx_data[15];
					tx_take <= 1'b1;
				end else begin
					tx   <= {tx[14:0], 1'b0};
					sdin <= tx[15];
				end
			end
		end
	end

	// ==========================================================
	// words from the adc, sampled on rising edge
	csp_word_t   rx;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rx        <= 16'h0000;
			rx_data   <= 16'h0000;
			rx_strobe <= 1'b0;
		end else begin
			rx_strobe <= 1'b0;
			if (rise) begin
				rx <= {rx[14:0], dout_q[1]};
				if (bidx == `CSP_FS_SLOT) begin
					rx_data   <= {rx[14:0], dout_q[1]};
					rx_strobe <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// pin drive
	assign link.master_sel = dev_master;
	assign link.pd_n_o     = pd_n;
	assign link.pd_n_oe    = 1'b1;
	assign link.h_bck_o    = bck_o;
	assign link.h_bck_oe   = ~dev_master;
	assign link.h_fs_o     = fs_o;
	assign link.h_fs_oe    = ~dev_master;
	assign link.serial_in  = sdin;
endmodule

// ===== csp_link_assertions.sv
// concurrent checks on the joined serial link
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_link_assertions #(
	parameter int INIT_CYC = `CSP_INIT_CYC,
	parameter int POST_CYC = `CSP_POST_CYC,
	parameter int HALF     = `CSP_BCK_HALF
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic master_sel,
	input wire logic power_down_n,
	input wire logic bit_clock,
	input wire logic frame_sync,
	input wire logic d_bck_oe,
	input wire logic d_fs_o,
	input wire logic d_fs_oe,
	input wire logic d_sdout_o,
	input wire logic d_sdout_oe
);
	// ==========================================
	// cycle counters
	int   fs_hi;
	int   bck_per;
	int   fs_per;
	int   up_cnt;
	int   oe_cnt;
	logic bck_q;
	logic fs_q;
	logic run_ok;

	assign run_ok = oe_cnt > 32 * HALF;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fs_hi <= 0;
			bck_per <= 0;
			fs_per <= 0;
			bck_q <= 1'h0;
			fs_q <= 1'h0;
		end else begin
			fs_hi <= frame_sync ? fs_hi + 1 : 0;
			bck_per <= (bit_clock && !bck_q) ? 1 : bck_per + 1;
			fs_per <= (frame_sync && !fs_q) ? 1 : fs_per + 1;
			bck_q <= bit_clock;
			fs_q <= frame_sync;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			up_cnt <= 0;
			oe_cnt <= 0;
		end else begin
			up_cnt <= power_down_n ? up_cnt + 1 : 0;
			oe_cnt <= d_sdout_oe ? oe_cnt + 1 : 0;
		end
	end

	// ==========================================
	// assertions
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	a_fs_one_bit: assert property (
		run_ok && $fell(frame_sync) |-> fs_hi == 2 * HALF) else $error("frame sync width");
	a_bck_period: assert property (
		run_ok && $rose(bit_clock) |-> bck_per == 2 * HALF) else $error("bit clock period");
	a_frame_len: assert property (
		run_ok && $rose(frame_sync) |-> fs_per == 32 * HALF) else $error("frame length");
	a_pd_out_off: assert property (
		(!power_down_n)[*6] |-> !d_sdout_oe) else $error("output driven in power down");
	a_init_hold_off: assert property (
		$rose(d_sdout_oe) |-> up_cnt >= INIT_CYC + POST_CYC) else $error("output before init");
	a_valid_bound: assert property (
		power_down_n && up_cnt == INIT_CYC + POST_CYC + 32 * HALF + 40 |-> d_sdout_oe)
		else $error("output never valid");
	a_dout_on_fall: assert property (
		$changed(d_sdout_o) && d_sdout_oe && $past(d_sdout_oe) |-> !bit_clock)
		else $error("data out launched off falling edge");
	a_fs_on_fall: assert property (
		$changed(d_fs_o) && d_fs_oe && $past(d_fs_oe) |-> !bit_clock)
		else $error("frame sync moved off falling edge");
	a_mode_pins: assert property (
		run_ok |-> d_bck_oe == master_sel && d_fs_oe == master_sel) else $error("clock pin direction");
endmodule

// ===== codec_serial_port_and_reset_tb.sv
// testbench joining codec end and controller end
`timescale 1ns/1ps
module codec_serial_port_and_reset_tb;
	import csp_pkg::*;
	localparam int INIT  = 16;
	localparam int POST  = 4;
	localparam int HALF  = 16;
	localparam int FRAME = 32 * HALF;

	logic      clock;
	logic      rstn;
	logic      master_mode;
	logic      pd_req;
	csp_word_t tx_data;
	csp_word_t adc_data;
	csp_word_t rx_data;
	csp_word_t dac_data;
	csp_word_t sh_out;
	csp_word_t sh_in;
	csp_word_t wire_out;
	csp_word_t wire_in;
	logic      tx_take;
	logic      rx_strobe;
	logic      adc_take;
	logic      dac_strobe;
	logic      data_valid;
	logic      master;
	int        n_fail;
	int        check_count;

	csp_if link();
	csp_codec #(.INIT_CYC(INIT), .POST_CYC(POST), .HALF(HALF)) i_csp_codec (
		.clock(clock), .rstn(rstn), .link(link), .adc_data(adc_data), .adc_take(adc_take),
		.dac_data(dac_data), .dac_strobe(dac_strobe), .data_valid(data_valid), .master(master));
	csp_host #(.HALF(HALF)) i_csp_host (
		.clock(clock), .rstn(rstn), .link(link), .master_mode(master_mode), .pd_req(pd_req),
		.tx_data(tx_data), .tx_take(tx_take), .rx_data(rx_data), .rx_strobe(rx_strobe));
	csp_link_assertions #(.INIT_CYC(INIT), .POST_CYC(POST), .HALF(HALF)) i_csp_link_assertions (
		.clock(clock), .rstn(rstn), .master_sel(link.master_sel),
		.power_down_n(link.power_down_n), .bit_clock(link.bit_clock),
		.frame_sync(link.frame_sync), .d_bck_oe(link.d_bck_oe), .d_fs_o(link.d_fs_o),
		.d_fs_oe(link.d_fs_oe), .d_sdout_o(link.d_sdout_o), .d_sdout_oe(link.d_sdout_oe));

	// ==========================================
	// clock and wire capture
	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end

	// words rebuilt from the wires, last bit in the sync slot
	always @(posedge link.bit_clock) begin
		sh_out = {sh_out[14:0], link.serial_out};
		sh_in = {sh_in[14:0], link.serial_in};
		if (link.frame_sync) begin
			wire_out = sh_out;
			wire_in = sh_in;
		end
	end

	// ==========================================
	// tasks
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic power_up(input logic mode);
		int n;
		int n_bad;
		@(negedge clock);
		pd_req = 1'h1;
		repeat (8) @(negedge clock);
		// mode strap moves only while held in power down
		master_mode = mode;
		repeat (8) @(negedge clock);
		check("valid in power down", data_valid, 1'h0);
		check("dout oe in power down", link.d_sdout_oe, 1'h0);
		check("dac in power down", dac_data, 16'h0000);
		pd_req = 1'h0;
		n = 0;
		n_bad = 0;
		while (data_valid !== 1'h1 && n < 200) begin
			n_bad += (dac_data !== 16'h0000 || link.d_sdout_oe !== 1'h0);
			@(negedge clock);
			n++;
		end
		check("init outputs held", n_bad, 16'h0000);
		check("init length", n >= INIT + POST, 1'h1);
		check("valid reached", data_valid, 1'h1);
		check("mode latched", master, mode);
	endtask

	task automatic xfer(input csp_word_t to_dac, input csp_word_t to_adc);
		int n_dac;
		int n_rx;
		int n_at;
		int n_tt;
		@(negedge clock);
		tx_data = to_dac;
		adc_data = to_adc;
		n_dac = 0;
		n_rx = 0;
		n_at = 0;
		n_tt = 0;
		repeat (4 * FRAME) begin
			@(negedge clock);
			n_dac += (dac_strobe === 1'h1);
			n_rx += (rx_strobe === 1'h1);
			n_at += (adc_take === 1'h1);
			n_tt += (tx_take === 1'h1);
		end
		check("dac words per frame", n_dac, 16'h0004);
		check("rx words per frame", n_rx, 16'h0004);
		check("adc takes per frame", n_at, 16'h0004);
		check("tx takes per frame", n_tt, 16'h0004);
		while (dac_strobe !== 1'h1 && n_dac < 8 + FRAME) begin
			@(negedge clock);
			n_dac++;
		end
		check("dac word", dac_data, to_dac);
		check("host word", rx_data, to_adc);
		check("wire adc word", wire_out, to_adc);
		check("wire dac word", wire_in, to_dac);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================
	// sequence and watchdog
	initial begin
		rstn = 1'h0;
		master_mode = 1'h0;
		pd_req = 1'h1;
		tx_data = 16'h0000;
		adc_data = 16'h0000;
		n_fail = 0;
		check_count = 0;
		repeat (10) @(negedge clock);
		rstn = 1'h1;
		power_up(1'h0);
		xfer(16'h8001, 16'h7FFE);
		xfer(16'hA5C3, 16'h0001);
		$display("test slave mode done");
		power_up(1'h1);
		xfer(16'h7FFF, 16'h8000);
		xfer(16'h0F0F, 16'hC35A);
		$display("test master mode done");
		complete_run();
	end

	initial begin
		#(25 * 40000);
		n_fail++;
		$display("ERROR watchdog expected finish seen timeout");
		complete_run();
	end
endmodule
